//--- rtl/dacc_regs.vh
/*
 * constants for the abstract command control block: offsets, field
 * positions, error codes, command types and reset values.
 * assumes inclusion by its bare name from the design files.
 */
`ifndef DACC_REGS_VH
`define DACC_REGS_VH

// ****************************************************************
// register indices on the debug module interface
// ****************************************************************
`define DACC_ADDR_CTRL_STATUS   7'h16
`define DACC_ADDR_COMMAND       7'h17
`define DACC_ADDR_DATA_FIRST    7'h04
`define DACC_ADDR_DATA_SECOND   7'h05

// ****************************************************************
// field positions
// ****************************************************************
`define DACC_BUSY_BIT           12
`define DACC_ERR_HI             10
`define DACC_ERR_LO             8
`define DACC_DCOUNT_HI          3
`define DACC_DCOUNT_LO          0
`define DACC_PBSIZE_HI          28
`define DACC_PBSIZE_LO          24
`define DACC_CTYPE_HI           31
`define DACC_CTYPE_LO           24
`define DACC_SIZE_HI            22
`define DACC_SIZE_LO            20
`define DACC_WRITE_BIT          16

// ****************************************************************
// values
// ****************************************************************
`define DACC_ERR_NONE           3'h0
`define DACC_ERR_BUSY           3'h1
`define DACC_ERR_NOTSUP         3'h2
`define DACC_ERR_EXCEPT         3'h3
`define DACC_ERR_HALTRES        3'h4
`define DACC_ERR_OTHER          3'h7
`define DACC_ERR_CLEAR          3'h7
`define DACC_CTYPE_REG          8'h00
`define DACC_CTYPE_MEM          8'h02
`define DACC_SIZE_32            3'h2
`define DACC_DATA_COUNT         4'h2
`define DACC_PBUF_SIZE          5'h00
`define DACC_REGNO_GPR_LAST     16'h101F

`endif

//--- rtl/dacc_range_check.v
/*
 * address range check for memory access commands.
 * assumes the three range bases and sizes are fixed by parameters.
 */
`timescale 1ns/1ps
`include "dacc_regs.vh"

module dacc_range_check #(
    parameter [31:0] INSTR_MEM_BASE = 32'hEE00_0000,
    parameter [31:0] INSTR_MEM_SIZE = 32'h0001_0000,
    parameter [31:0] DATA_MEM_BASE  = 32'hF004_0000,
    parameter [31:0] DATA_MEM_SIZE  = 32'h0001_0000,
    parameter [31:0] INTC_BASE      = 32'hF00C_0000,
    parameter [31:0] INTC_SIZE      = 32'h0000_8000
) (
    addr,
    inRange,
    aligned
);
    input  wire [31:0] addr;
    output wire        inRange;
    output wire        aligned;

    // ****************************************************************
    // window compare
    // ****************************************************************
    function inWin;
        input [31:0] a;
        input [31:0] base;
        input [31:0] size;
        begin
            inWin = (a >= base) && ((a - base) < size);
        end
    endfunction

    // only the two tightly coupled memories and interrupt range reachable
    assign inRange = inWin(addr, INSTR_MEM_BASE, INSTR_MEM_SIZE) ||
                     inWin(addr, DATA_MEM_BASE, DATA_MEM_SIZE) ||
                     inWin(addr, INTC_BASE, INTC_SIZE);
    assign aligned = (addr[1:0] == 2'b00);
endmodule // dacc_range_check

//--- rtl/dacc_ctrl.v
/*
 * abstract command control and status for the debug module: command
 * launch, busy flag, sticky error code, data register guard.
 * assumes a single debug module clock, a debug module interface strobe
 * per access, and a hart side that pulses execDone when work ends.
 * assumes memAddr carries the second data register for memory
 * commands, and that the hart status inputs stay steady while a
 * command word is written. a command only launches on a halted,
 * present hart that is not running.
 * assumes the debugger polls busy before it trusts the error code,
 * since the code may still change while a command runs.
 * assumes nothing of the data registers beyond their two indices.
 */
`timescale 1ns/1ps
`include "dacc_regs.vh"

// Contract
// - command word write launches command when no error pending
// - busy bit 12 set on command write, cleared on completion
// - control word write while busy sets error 1 if error was 0
// - command word write while busy sets error 1 if error was 0
// - data register access while busy sets error 1 if error was 0
// - nonzero error ignores command writes, starts nothing
// - 3-bit error code at bits 10:8, zero means no error
// - unsupported command reports error 2
// - address outside allowed memory ranges reports error 3
// - hart in wrong state or unavailable reports error 4
// - size not 32 bits or unaligned reports error 7
// - error 5 never produced, error 6 unused
// - error stays set until debugger writes 111 to field while not busy
// - data count bits 3:0 read as 2
// - program buffer size reads zero, reserved bits zero
// - memory commands reach only tightly coupled and interrupt ranges
// - type 0 register access, 2 memory access, others unsupported
// - access size other than 2 fails with error 7
module dacc_ctrl #(
    parameter ADDR_W = 7
) (
    sys_clk,
    sys_rst,
    dmiValid,
    dmiWrite,
    dmiAddr,
    dmiWdata,
    dmiRdata,
    hartHalted,
    hartRunning,
    hartUnavail,
    memAddr,
    execStart,
    execCmd,
    execDone,
    busy,
    errCode
);
    input  wire              sys_clk;
    input  wire              sys_rst;
    input  wire              dmiValid;
    input  wire              dmiWrite;
    input  wire [ADDR_W-1:0] dmiAddr;
    input  wire [31:0]       dmiWdata;
    output reg  [31:0]       dmiRdata;
    input  wire              hartHalted;
    input  wire              hartRunning;
    input  wire              hartUnavail;
    input  wire [31:0]       memAddr;
    output reg               execStart;
    output reg  [31:0]       execCmd;
    input  wire              execDone;
    output wire              busy;
    output wire [2:0]        errCode;

    // ****************************************************************
    // state
    // ****************************************************************
    // two states: idle, or one command running on the hart side
    localparam ST_IDLE = 1'b0;
    localparam ST_EXEC = 1'b1;

    reg         state_r;
    reg         state_nxt;
    reg  [2:0]  err_r;
    reg  [2:0]  err_nxt;
    reg         start_nxt;
    reg  [31:0] cmd_nxt;
    reg  [2:0]  failCode;
    reg  [31:0] rdata_nxt;
    wire        memInRange;
    wire        memAligned;
    wire        accCs;
    wire        accCmd;
    wire        accData;
    wire        csWrite;
    wire        csRead;
    wire        anyBusyHit;
    wire [7:0]  cType;
    wire [2:0]  cSize;
    wire [15:0] regNo;
    wire        regCmd;
    wire        memCmd;
    wire        typeKnown;
    wire        hartReady;
    wire        errClean;
    wire [31:0] statusWord;

    // ****************************************************************
    // helper functions
    // ****************************************************************
    // index match on the interface, only while the strobe stands
    function regHit;
        input              strobe;
        input [ADDR_W-1:0] idx;
        input [ADDR_W-1:0] want;
        begin
            regHit = strobe && (idx == want);
        end
    endfunction

    // command type field of a command word
    function [7:0] fieldType;
        input [31:0] word;
        begin
            fieldType = word[`DACC_CTYPE_HI:`DACC_CTYPE_LO];
        end
    endfunction

    // access size field, same place for register and memory commands
    function [2:0] fieldSize;
        input [31:0] word;
        begin
            fieldSize = word[`DACC_SIZE_HI:`DACC_SIZE_LO];
        end
    endfunction

    // register number field of a register access command
    function [15:0] fieldRegNo;
        input [31:0] word;
        begin
            fieldRegNo = word[15:0];
        end
    endfunction

    // write-one clear: only the full 111 pattern in the field clears
    function clearHit;
        input        wr;
        input [31:0] word;
        begin
            clearHit = wr &&
                (word[`DACC_ERR_HI:`DACC_ERR_LO] == `DACC_ERR_CLEAR);
        end
    endfunction

    // busy error only lands on a clean code, else the code is kept
    function [2:0] busyErr;
        input [2:0] err;
        begin
            if (err == `DACC_ERR_NONE) begin
                busyErr = `DACC_ERR_BUSY;
            end else begin
                busyErr = err;
            end
        end
    endfunction

    // status word as the debugger reads it, reserved bits zero
    function [31:0] ctrlWord;
        input       busyBit;
        input [2:0] err;
        begin
            ctrlWord = 32'h0000_0000;
            ctrlWord[`DACC_PBSIZE_HI:`DACC_PBSIZE_LO] = `DACC_PBUF_SIZE;
            ctrlWord[`DACC_BUSY_BIT] = busyBit;
            ctrlWord[`DACC_ERR_HI:`DACC_ERR_LO] = err;
            ctrlWord[`DACC_DCOUNT_HI:`DACC_DCOUNT_LO] =
                `DACC_DATA_COUNT;
        end
    endfunction

    // ****************************************************************
    // access decode
    // ****************************************************************
    // control word reached for read or write
    assign accCs   = regHit(dmiValid, dmiAddr, `DACC_ADDR_CTRL_STATUS);
    // command word is write only
    assign accCmd  = regHit(dmiValid, dmiAddr, `DACC_ADDR_COMMAND) &&
                     dmiWrite;
    // either data register, read or write
    assign accData = regHit(dmiValid, dmiAddr, `DACC_ADDR_DATA_FIRST) ||
                     regHit(dmiValid, dmiAddr, `DACC_ADDR_DATA_SECOND);
    assign csWrite = accCs && dmiWrite;
    assign csRead  = accCs && !dmiWrite;
    // any access that collides with a running command
    assign anyBusyHit = csWrite || accCmd || accData;

    // ****************************************************************
    // command fields and hart readiness
    // ****************************************************************
    assign cType = fieldType(dmiWdata);
    assign cSize = fieldSize(dmiWdata);
    assign regNo = fieldRegNo(dmiWdata);
    // which of the two command kinds the word asks for
    assign regCmd    = (cType == `DACC_CTYPE_REG);
    assign memCmd    = (cType == `DACC_CTYPE_MEM);
    assign typeKnown = regCmd || memCmd;
    // commands need a present, halted, not running hart
    assign hartReady = !hartUnavail && hartHalted && !hartRunning;
    // a pending code blocks every launch
    assign errClean  = (err_r == `DACC_ERR_NONE);
    assign statusWord = ctrlWord(busy, err_r);

    assign busy    = (state_r == ST_EXEC);
    assign errCode = err_r;

    dacc_range_check uRange (
        .addr    (memAddr),
        .inRange (memInRange),
        .aligned (memAligned)
    );

    // ****************************************************************
    // command check, priority: type, size, register number, hart state, address
    // ****************************************************************
    always @* begin
        failCode = `DACC_ERR_NONE;
        if (!typeKnown) begin
            failCode = `DACC_ERR_NOTSUP;
        end else if (cSize != `DACC_SIZE_32) begin
            failCode = `DACC_ERR_OTHER;
        end else if (regCmd && (regNo > `DACC_REGNO_GPR_LAST)) begin
            failCode = `DACC_ERR_NOTSUP;
        end else if (!hartReady) begin
            failCode = `DACC_ERR_HALTRES;
        end else if (memCmd && !memAligned) begin
            failCode = `DACC_ERR_OTHER;
        end else if (memCmd && !memInRange) begin
            failCode = `DACC_ERR_EXCEPT;
        end
    end

    // ****************************************************************
    // next state, error code and launch
    // ****************************************************************
    always @* begin
        state_nxt = state_r;
        err_nxt   = err_r;
        start_nxt = 1'b0;
        cmd_nxt   = execCmd;
        // write-one clear, only the full 111 pattern clears
        if (clearHit(csWrite, dmiWdata)) begin
            err_nxt = `DACC_ERR_NONE;
        end
        case (state_r)
            ST_IDLE: begin
                if (accCmd && errClean) begin
                    if (failCode == `DACC_ERR_NONE) begin
                        state_nxt = ST_EXEC;
                        start_nxt = 1'b1;
                        cmd_nxt   = dmiWdata;
                    end else begin
                        err_nxt = failCode;
                    end
                end
            end
            ST_EXEC: begin
                if (execDone) begin
                    state_nxt = ST_IDLE;
                end
                // busy error set wins over clear; only from zero
                if (anyBusyHit) begin
                    err_nxt = busyErr(err_r);
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    // command interface state
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // sticky error code
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            err_r <= `DACC_ERR_NONE;
        end else begin
            err_r <= err_nxt;
        end
    end

    // launch pulse and the latched command word for the hart side
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            execStart <= 1'b0;
            execCmd   <= 32'h0000_0000;
        end else begin
            execStart <= start_nxt;
            execCmd   <= cmd_nxt;
        end
    end

    // ****************************************************************
    // read data, registered one cycle after the read strobe
    // ****************************************************************
    // next read word; anything but a read keeps the last word
    always @* begin
        rdata_nxt = dmiRdata;
        if (csRead) begin
            rdata_nxt = statusWord;
        end else if (dmiValid && !dmiWrite) begin
            rdata_nxt = 32'h0000_0000;       // other indices read zero
        end
    end

    // holds its value until the next read
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            dmiRdata <= 32'h0000_0000;
        end else begin
            dmiRdata <= rdata_nxt;
        end
    end
endmodule // dacc_ctrl

//--- test/dacc_ctrl_asserts.sv
/* port-level checks for dacc_ctrl.
   assumes one clock, sys_rst synchronous and active high. */
`timescale 1ns/1ps
module dacc_ctrl_asserts #(parameter ADDR_W = 7) (
    input wire logic              sys_clk, sys_rst, dmiValid, dmiWrite,
    input wire logic [ADDR_W-1:0] dmiAddr,
    input wire logic [31:0]       dmiWdata, dmiRdata, memAddr, execCmd,
    input wire logic              hartHalted, hartRunning, hartUnavail,
    input wire logic              execStart, execDone, busy,
    input wire logic [2:0]        errCode
);
    // decoded accesses
    wire cmdWr = dmiValid && dmiWrite && dmiAddr == 7'h17;
    wire csWr  = dmiValid && dmiWrite && dmiAddr == 7'h16;
    wire datAc = dmiValid && (dmiAddr == 7'h04 || dmiAddr == 7'h05);
    wire idle0 = !busy && errCode == 3'h0;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    a_start_busy: assert property (execStart |-> busy)
        else $error("launch without busy");
    a_done_idle: assert property (busy && execDone |=> !busy)
        else $error("busy after done");
    a_cmd_busy: assert property (cmdWr && busy && errCode == 3'h0
        |=> errCode == 3'h1 && !execStart) else $error("cmd busy err");
    a_cs_busy: assert property (csWr && busy && errCode == 3'h0
        |=> errCode == 3'h1) else $error("ctrl busy err");
    a_data_busy: assert property (datAc && busy && errCode == 3'h0
        |=> errCode == 3'h1) else $error("data busy err");
    a_err_blocks: assert property (cmdWr && errCode != 3'h0
        |=> !execStart && $stable(errCode)) else $error("cmd not blocked");
    a_err_sticky: assert property (errCode != 3'h0 &&
        !(csWr && dmiWdata[10:8] == 3'h7) |=> $stable(errCode))
        else $error("error code moved");
    a_no_code: assert property (errCode != 3'h5 && errCode != 3'h6)
        else $error("unused error code");
    a_bad_type: assert property (cmdWr && idle0 &&
        dmiWdata[31:24] != 8'h00 && dmiWdata[31:24] != 8'h02
        |=> errCode == 3'h2 && !execStart) else $error("type not refused");
    a_bad_size: assert property (cmdWr && idle0 &&
        dmiWdata[31:24] == 8'h00 && dmiWdata[22:20] != 3'h2
        |=> errCode == 3'h7) else $error("size not refused");
    a_ctrl_const: assert property (dmiValid && !dmiWrite &&
        dmiAddr == 7'h16 |=> dmiRdata[31:13] == 19'h0_0000 &&
        dmiRdata[11] == 1'b0 && dmiRdata[7:0] == 8'h02)
        else $error("ctrl fixed fields");
    a_launch: assert property (cmdWr && idle0 && hartHalted &&
        !hartUnavail && !hartRunning && dmiWdata == 32'h0022_1000
        |=> execStart && execCmd == 32'h0022_1000) else $error("no launch");
endmodule // dacc_ctrl_asserts

bind dacc_ctrl dacc_ctrl_asserts #(.ADDR_W(ADDR_W)) u_chk (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .dmiValid(dmiValid),
    .dmiWrite(dmiWrite), .dmiAddr(dmiAddr), .dmiWdata(dmiWdata),
    .dmiRdata(dmiRdata), .memAddr(memAddr), .execCmd(execCmd),
    .hartHalted(hartHalted), .hartRunning(hartRunning),
    .hartUnavail(hartUnavail), .execStart(execStart),
    .execDone(execDone), .busy(busy), .errCode(errCode));

//--- test/dacc_hart_model.sv
/* hart-side stand-in: answers each launch with one done pulse.
   assumes lat is at least one and held while a command runs. */
`timescale 1ns/1ps
module dacc_hart_model (
    input  wire logic       sys_clk, sys_rst, execStart,
    input  wire logic [3:0] lat,
    output logic            execDone
);
    logic [3:0] cnt_r;
    // count down from launch, pulse done when it runs out
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            cnt_r    <= 4'h0;
            execDone <= 1'b0;
        end else begin
            execDone <= (cnt_r == 4'h1);
            if (execStart) cnt_r <= lat;
            else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
        end
    end
endmodule // dacc_hart_model

//--- test/dacc_ctrl_tb.sv
/* self-checking bench for dacc_ctrl.
   assumes dacc_hart_model as hart side and the checker bound in. */
`timescale 1ns/1ps
module dacc_ctrl_tb;
    logic        sys_clk = 0, sys_rst = 1, dmiValid = 0, dmiWrite = 0;
    logic [6:0]  dmiAddr = 7'h00;
    logic [31:0] dmiWdata = 32'h0, memAddr = 32'h0, dmiRdata, execCmd;
    logic        hartHalted = 1, hartRunning = 0, hartUnavail = 0;
    logic        execStart, execDone, busy;
    logic [2:0]  errCode;
    logic [3:0]  lat = 4'h1;
    int          miscompares = 0, total_checks = 0, starts = 0;
    localparam logic [31:0] CMD = 32'h0022_1000;
    localparam logic [31:0] CLR = 32'h0000_0700;

    dacc_ctrl DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .dmiValid(dmiValid), .dmiWrite(dmiWrite), .dmiAddr(dmiAddr),
        .dmiWdata(dmiWdata), .dmiRdata(dmiRdata), .hartHalted(hartHalted),
        .hartRunning(hartRunning), .hartUnavail(hartUnavail),
        .memAddr(memAddr), .execStart(execStart), .execCmd(execCmd),
        .execDone(execDone), .busy(busy), .errCode(errCode));
    dacc_hart_model u_hart (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .execStart(execStart), .lat(lat), .execDone(execDone));

    // clock and launch counter
    initial forever #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (execStart === 1'b1) starts++;

    task chk(input string n, input logic [31:0] s, e);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED %s exp %h seen %h", n, e, s);
        end
    endtask
    // one strobe cycle; read data settled on return
    task acc(input logic w, input logic [6:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        dmiValid <= 1'b1; dmiWrite <= w; dmiAddr <= a; dmiWdata <= d;
        @(posedge sys_clk);
        dmiValid <= 1'b0;
        #1;
    endtask
    // poll busy before anything else is issued
    task idle;
        for (int i = 0; i < 40; i++) begin
            acc(1'b0, 7'h16, 32'h0);
            if (dmiRdata[12] === 1'b0) break;
        end
        chk("idle", {31'h0, dmiRdata[12]}, 32'h0);
        chk("busy port", {31'h0, busy}, 32'h0);
    endtask
    task s_reset;
        acc(1'b1, 7'h16, 32'hFFFF_FFFF);
        acc(1'b0, 7'h16, 32'h0);
        chk("ctrl reset", dmiRdata, 32'h0000_0002);
    endtask
    task s_busy;
        lat = 4'hC;
        acc(1'b1, 7'h17, CMD); acc(1'b1, 7'h16, 32'h0); acc(1'b1, 7'h16, CLR);
        idle; chk("ctrl busy", dmiRdata, 32'h0000_0102);
        chk("cmd word", execCmd, CMD);
        acc(1'b1, 7'h16, CLR); acc(1'b1, 7'h17, CMD); acc(1'b1, 7'h17, CMD);
        idle; chk("cmd busy", dmiRdata, 32'h0000_0102);
        chk("launches", 32'(starts), 32'h2);
        acc(1'b1, 7'h16, CLR); acc(1'b1, 7'h17, CMD); acc(1'b0, 7'h05, 32'h0);
        idle; chk("data busy", dmiRdata, 32'h0000_0102);
        acc(1'b1, 7'h17, CMD); idle;
        chk("blocked", 32'(starts), 32'h3);
        acc(1'b1, 7'h16, CLR);
    endtask
    task runc(input logic [31:0] c, ma, input logic h, u, input logic [2:0] e);
        @(posedge sys_clk);
        memAddr <= ma; hartHalted <= h; hartRunning <= !h; hartUnavail <= u;
        acc(1'b1, 7'h17, c); idle;
        chk("err code", {29'h0, dmiRdata[10:8]}, {29'h0, e});
        chk("err port", {29'h0, errCode}, {29'h0, e});
        acc(1'b1, 7'h16, CLR);
    endtask
    task s_errors;
        lat = 4'h1;
        runc(32'h0122_1000, 32'h0, 1, 0, 3'h2);
        runc(CMD, 32'h0, 1, 0, 3'h0);
        runc(32'h0012_1000, 32'h0, 1, 0, 3'h7);
        runc(32'h0022_1020, 32'h0, 1, 0, 3'h2);
        runc(CMD, 32'h0, 0, 0, 3'h4);
        runc(CMD, 32'h0, 1, 1, 3'h4);
        runc(32'h0222_0000, 32'hF004_0000, 1, 0, 3'h0);
        runc(32'h0222_0000, 32'hF004_0002, 1, 0, 3'h7);
        runc(32'h0222_0000, 32'h1000_0000, 1, 0, 3'h3);
    endtask
    task end_sim;
        if (miscompares == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        s_reset; s_busy; s_errors; end_sim;
    end
    // watchdog
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        end_sim;
    end
endmodule // dacc_ctrl_tb
